/* File: pkg/hpp_consts.svh */
/*
 * Constants of the parallel host port: timing, register offsets and field positions.
 * Assumes a 125 MHz ref_clk; included by bare name from the bench and both ends.
 */
`ifndef HPP_CONSTS_SVH
`define HPP_CONSTS_SVH

`define HPP_CLK_NS 8
`define HPP_STROBE_NS 64
`define HPP_STROBE_CYC ((`HPP_STROBE_NS + `HPP_CLK_NS - 1) / `HPP_CLK_NS)
`define HPP_SETUP_NS 16
`define HPP_SETUP_CYC ((`HPP_SETUP_NS + `HPP_CLK_NS - 1) / `HPP_CLK_NS)
`define HPP_FIFO_DEPTH 16
`define HPP_FIFO_ADDR 4'h0

// device user-side registers
`define HPP_DEV_CTRL 5'h00
`define HPP_DEV_STATUS 5'h01
`define HPP_DEV_RXREQ 5'h02
`define HPP_DEV_HREG_BIT 4
`define HPP_DEV_CTRL_RESET 4'h0
`define HPP_CTRL_REQ_POL 0
`define HPP_CTRL_REQ_OD 1
`define HPP_CTRL_ACK_POL 2
`define HPP_CTRL_DOUBLE_REQ 3
`define HPP_STAT_OVERFLOW 0
`define HPP_STAT_RXPEND 1
`define HPP_STAT_FULL 2
`define HPP_STAT_ENABLED 3

// host user-side registers
`define HPP_HST_CMD 3'h0
`define HPP_HST_ADDR 3'h1
`define HPP_HST_WDATA 3'h2
`define HPP_HST_CFG 3'h3
`define HPP_HST_STATUS 3'h4
`define HPP_HST_RDATA 3'h5
`define HPP_CMD_GO 0
`define HPP_CMD_READ 1
`define HPP_CMD_ACK 2
`define HPP_CFG_STROBE_POL 0
`define HPP_CFG_DUAL 1
`define HPP_CFG_BYTE 2
`define HPP_CFG_REQ_POL 3
`define HPP_CFG_ACK_POL 4
`define HPP_HST_CFG_RESET 5'h01

`endif

/* File: pkg/hpp_if.sv */
/*
 * Pin bundle between the device end and the host end, with wire resolution.
 * Assumes pull-ups on every shared wire; no end drives high impedance itself.
 */
`timescale 1ns/1ps
interface hpp_if;
	logic [15:0] dataHost;
	logic [15:0] dataHostOe;
	logic [15:0] dataDev;
	logic [15:0] dataDevOe;
	logic [15:0] dataBus;
	logic [3:0] addr;
	logic selA;
	logic selB;
	logic rw;
	logic readStrobe;
	logic writeStrobe;
	logic singleStrobe;
	logic ack;
	logic strobePol;
	logic dualStrobe;
	logic byteWidth;
	logic svcReqOut;
	logic svcReqOe;
	logic svcReq;
	logic txReqOut;
	logic txReqOe;
	logic txReq;
	logic rxReqOut;
	logic rxReqOe;
	logic rxReq;

	// device wins a clash bit by bit; an undriven bit floats high
	assign dataBus = (dataDevOe & dataDev) | (~dataDevOe & dataHostOe & dataHost)
		| (~dataDevOe & ~dataHostOe);
	assign svcReq = svcReqOe ? svcReqOut : 1'b1;
	assign txReq = txReqOe ? txReqOut : 1'b1;
	assign rxReq = rxReqOe ? rxReqOut : 1'b1;

	modport dev (
		input dataBus, addr, selA, selB, rw, readStrobe, writeStrobe, singleStrobe, ack,
		input strobePol, dualStrobe, byteWidth,
		output dataDev, dataDevOe, svcReqOut, svcReqOe, txReqOut, txReqOe, rxReqOut, rxReqOe
	);
	modport host (
		input dataBus, svcReq, txReq, rxReq,
		output dataHost, dataHostOe, addr, selA, selB, rw, readStrobe, writeStrobe,
		output singleStrobe, ack, strobePol, dualStrobe, byteWidth
	);
endinterface

/* File: pkg/hpp_pkg.sv */
/*
 * Types of the parallel host port; only the host end uses them.
 * Assumes hpp_consts.svh on the include path.
 */
package hpp_pkg;
	typedef logic [15:0] hpp_word_t;
	typedef enum logic [1:0] {HPP_IDLE, HPP_SETUP, HPP_STROBE, HPP_HOLD} hpp_state_e;
endpackage

/* File: testbench/hpp_monitor.sv */
/*
 * Pin-level checker for the host port, watching the bundle between the two ends.
 * Assumes one clock domain and the device's host port enable level beside the bundle.
 */
`timescale 1ns/1ps

module hpp_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hostPortEnable,
	input wire logic selA,
	input wire logic selB,
	input wire logic rw,
	input wire logic readStrobe,
	input wire logic writeStrobe,
	input wire logic singleStrobe,
	input wire logic strobePol,
	input wire logic dualStrobe,
	input wire logic byteWidth,
	input wire logic [15:0] dataDev,
	input wire logic [15:0] dataDevOe,
	input wire logic svcReqOe,
	input wire logic txReqOe,
	input wire logic rxReqOe
);
	default clocking mon_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	logic picked;
	logic readAct;
	logic writeAct;
	assign picked = hostPortEnable && (selA || selB);
	assign readAct = picked && (dualStrobe ? readStrobe == strobePol
		: singleStrobe == strobePol && rw);
	assign writeAct = picked && (dualStrobe ? writeStrobe == strobePol
		: singleStrobe == strobePol && !rw);

	////////////////////////////////////////////////////////////////////////////////
	// held strobes must outlast the two-flop synchroniser before any response
	sequence s_read_held;
		readAct [*6];
	endsequence
	sequence s_write_held;
		writeAct [*6];
	endsequence
	sequence s_unselected;
		(hostPortEnable && !(selA || selB)) [*4];
	endsequence

	a_read_drives_bus: assert property (s_read_held |-> dataDevOe != 16'h0000)
		else $error("data bus not driven during a held read");
	a_idle_bus_free: assert property (s_unselected |-> dataDevOe == 16'h0000)
		else $error("data bus driven while port not selected");
	a_write_bus_free: assert property (s_write_held |-> dataDevOe == 16'h0000)
		else $error("data bus driven during a host write");
	a_read_release: assert property ($fell(readAct) && hostPortEnable
		|-> ##[1:6] dataDevOe == 16'h0000)
		else $error("data bus not released after read strobe");
	a_width_lanes: assert property (hostPortEnable && dataDevOe != 16'h0000
		|-> dataDevOe == (byteWidth ? 16'h00ff : 16'hffff))
		else $error("driven lanes do not match width select");
	a_data_steady: assert property (hostPortEnable && $past(hostPortEnable)
		&& dataDevOe != 16'h0000 && $past(dataDevOe) != 16'h0000 |-> $stable(dataDev))
		else $error("read data changed while driven");
	a_one_scheme: assert property (!(svcReqOe && (txReqOe || rxReqOe)))
		else $error("single and double request pins driven together");
	a_req_released: assert property ((!hostPortEnable) [*2]
		|-> !svcReqOe && !txReqOe && !rxReqOe)
		else $error("request pins driven while port disabled");
endmodule

/* File: testbench/testbench.sv */
/*
 * Self-checking bench: host end and device end joined by hpp_if, both user sides driven.
 * Assumes the design files, the package and hpp_consts.svh on the include path.
 */
`timescale 1ns/1ps
`include "hpp_consts.svh"

module testbench;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] dAddr = 5'h00;
	logic [2:0] hAddr = 3'h0;
	logic [15:0] dWd = 16'h0000;
	logic [15:0] hWd = 16'h0000;
	logic dW = 1'b0;
	logic dR = 1'b0;
	logic hW = 1'b0;
	logic hR = 1'b0;
	logic [15:0] dRd;
	logic [15:0] host_read_strobe;
	logic hpe = 1'b1;
	logic sysOnly = 1'b0;
	logic [15:0] sysDo = 16'h0000;
	logic sysDoe = 1'b0;
	logic [15:0] sysDi;
	logic [2:0] sysTo = 3'h0;
	logic sysToe = 1'b0;
	logic [2:0] sysTpo;
	logic sysTpoe;
	logic [2:0] sysTpi = 3'h0;
	logic [2:0] sysTi;
	logic [15:0] rxData;
	logic rxValid;
	logic rxReady = 1'b0;
	logic [15:0] v;
	int err_total = 0;
	int compares = 0;

	hpp_if hp();
	hpp_device #(.DW(16), .DEPTH(16)) hpp_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .hp(hp),
		.hostPortEnable(hpe), .sysOnlyMode(sysOnly), .sysDataOut(sysDo), .sysDataOe(sysDoe),
		.sysDataIn(sysDi), .sysTopOut(sysTo), .sysTopOe(sysToe), .sysTopPinOut(sysTpo),
		.sysTopPinOe(sysTpoe), .sysTopPinIn(sysTpi), .sysTopIn(sysTi), .regAddr(dAddr),
		.regWdata(dWd), .regWrite(dW), .regRead(dR), .regRdata(dRd), .rxData(rxData),
		.rxValid(rxValid), .rxReady(rxReady));
	hpp_host hpp_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .hp(hp), .regAddr(hAddr),
		.regWdata(hWd), .regWrite(hW), .regRead(hR), .regRdata(host_read_strobe));
	hpp_monitor hpp_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n), .hostPortEnable(hpe),
		.selA(hp.selA), .selB(hp.selB), .rw(hp.rw), .readStrobe(hp.readStrobe),
		.writeStrobe(hp.writeStrobe), .singleStrobe(hp.singleStrobe), .strobePol(hp.strobePol),
		.dualStrobe(hp.dualStrobe), .byteWidth(hp.byteWidth), .dataDev(hp.dataDev),
		.dataDevOe(hp.dataDevOe), .svcReqOe(hp.svcReqOe), .txReqOe(hp.txReqOe),
		.rxReqOe(hp.rxReqOe));

	initial begin
		forever #4 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one-cycle strobe; read data stand only in the following cycle
	task automatic acc(input bit host, input bit wr, input logic [4:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge ref_clk);
		dAddr <= a;
		hAddr <= a[2:0];
		dWd <= d;
		hWd <= d;
		hW <= host & wr;
		hR <= host & !wr;
		dW <= !host & wr;
		dR <= !host & !wr;
		@(posedge ref_clk);
		{hW, hR, dW, dR} <= 4'h0;
		#1 q = host ? host_read_strobe : dRd;
	endtask

	task automatic dAcc(input bit wr, input logic [4:0] a, input logic [15:0] d,
		output logic [15:0] q);
		acc(1'b0, wr, a, d, q);
	endtask

	task automatic hAcc(input bit wr, input logic [2:0] a, input logic [15:0] d,
		output logic [15:0] q);
		acc(1'b1, wr, {2'b00, a}, d, q);
	endtask

	// one pin-level access by the host end; polls busy so slow strobes still finish
	task automatic pin(input logic [3:0] a, input logic [15:0] d, input bit rd,
		output logic [15:0] q);
		hAcc(1'b1, `HPP_HST_ADDR, {12'h000, a}, q);
		hAcc(1'b1, `HPP_HST_WDATA, d, q);
		hAcc(1'b1, `HPP_HST_CMD, rd ? 16'h0003 : 16'h0001, q);
		for (int i = 0; i < 40; i++) begin
			hAcc(1'b0, `HPP_HST_STATUS, 16'h0000, q);
			if (q[0] === 1'b0) break;
		end
		hAcc(1'b0, `HPP_HST_RDATA, 16'h0000, q);
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		dAcc(1'b0, `HPP_DEV_CTRL, 16'h0000, v);
		chk("device ctrl", v, 16'h0000);
		hAcc(1'b0, `HPP_HST_CFG, 16'h0000, v);
		chk("host cfg", v, 16'h0001);
		dAcc(1'b0, 5'h07, 16'h0000, v);
		chk("unmapped", v, 16'h0000);
		$display("test reset values done");
		// every strobe scheme and polarity, each on its own register
		for (int m = 0; m < 4; m++) begin
			hAcc(1'b1, `HPP_HST_CFG, {14'h0000, m[1:0]}, v);
			pin(4'h1 + m[3:0], 16'h5a00 + m[15:0], 1'b0, v);
			dAcc(1'b0, 5'h11 + m[4:0], 16'h0000, v);
			chk("pin write", v, 16'h5a00 + m[15:0]);
			pin(4'h1 + m[3:0], 16'h0000, 1'b1, v);
			chk("pin read", v, 16'h5a00 + m[15:0]);
		end
		$display("test strobe modes done");
		dAcc(1'b1, 5'h16, 16'h1234, v);
		hAcc(1'b1, `HPP_HST_CFG, 16'h0005, v);
		pin(4'h6, 16'ha5c3, 1'b0, v);
		dAcc(1'b0, 5'h16, 16'h0000, v);
		chk("byte write", v, 16'h12c3);
		pin(4'h6, 16'h0000, 1'b1, v);
		chk("byte read", v, 16'h00c3);
		$display("test byte width done");
		// fill with the reader stalled; the seventeenth word must be dropped
		hAcc(1'b1, `HPP_HST_CFG, 16'h0001, v);
		for (int i = 0; i < 17; i++) begin
			pin(4'h0, 16'hc000 + i[15:0], 1'b0, v);
		end
		dAcc(1'b0, `HPP_DEV_STATUS, 16'h0000, v);
		chk("status full", v, 16'h000d);
		dAcc(1'b1, `HPP_DEV_CTRL, 16'h0009, v);
		chk("tx idle", {15'h0000, hp.txReq}, 16'h0000);
		@(posedge ref_clk);
		rxReady <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			#1 chk("fifo head", rxData, 16'hc000 + i[15:0]);
			@(posedge ref_clk);
		end
		rxReady <= 1'b0;
		#1 chk("fifo empty", {15'h0000, rxValid}, 16'h0000);
		dAcc(1'b1, `HPP_DEV_STATUS, 16'h0001, v);
		dAcc(1'b0, `HPP_DEV_STATUS, 16'h0000, v);
		chk("status clear", v, 16'h0008);
		chk("tx room", {15'h0000, hp.txReq}, 16'h0001);
		dAcc(1'b1, `HPP_DEV_RXREQ, 16'h0001, v);
		chk("rx request", {15'h0000, hp.rxReq}, 16'h0001);
		pin(4'h1, 16'h0000, 1'b1, v);
		chk("rx served", {15'h0000, hp.rxReq}, 16'h0000);
		$display("test fifo and double request done");
		dAcc(1'b1, `HPP_DEV_CTRL, 16'h0000, v);
		chk("svc idle", {15'h0000, hp.svcReq}, 16'h0001);
		dAcc(1'b1, `HPP_DEV_RXREQ, 16'h0001, v);
		chk("svc active", {15'h0000, hp.svcReq}, 16'h0000);
		hAcc(1'b0, `HPP_HST_STATUS, 16'h0000, v);
		chk("host sees svc", {15'h0000, v[1]}, 16'h0001);
		hAcc(1'b1, `HPP_HST_CMD, 16'h0004, v);
		// ack pulse plus synchroniser delay
		repeat (12) @(posedge ref_clk);
		#1 chk("svc acked", {15'h0000, hp.svcReq}, 16'h0001);
		dAcc(1'b1, `HPP_DEV_CTRL, 16'h0003, v);
		chk("od pull low", {15'h0000, hp.svcReq}, 16'h0000);
		dAcc(1'b1, `HPP_DEV_RXREQ, 16'h0001, v);
		chk("od released", {15'h0000, hp.svcReq}, 16'h0001);
		// active-high request and acknowledge on both ends
		hAcc(1'b1, `HPP_HST_CFG, 16'h0019, v);
		dAcc(1'b1, `HPP_DEV_CTRL, 16'h0005, v);
		dAcc(1'b1, `HPP_DEV_RXREQ, 16'h0001, v);
		chk("svc high active", {15'h0000, hp.svcReq}, 16'h0001);
		hAcc(1'b0, `HPP_HST_STATUS, 16'h0000, v);
		chk("host sees high svc", {15'h0000, v[1]}, 16'h0001);
		hAcc(1'b1, `HPP_HST_CMD, 16'h0004, v);
		repeat (12) @(posedge ref_clk);
		#1 chk("svc high acked", {15'h0000, hp.svcReq}, 16'h0000);
		$display("test single request done");
		@(posedge ref_clk);
		hpe <= 1'b0;
		sysDo <= 16'h3c96;
		sysDoe <= 1'b1;
		sysTo <= 3'h5;
		sysToe <= 1'b1;
		sysTpi <= 3'h6;
		repeat (2) @(posedge ref_clk);
		#1 chk("sys drive", hp.dataBus, 16'h3c96);
		chk("sys in", sysDi, 16'h3c96);
		chk("req free", {13'h0000, hp.svcReq, hp.txReq, hp.rxReq}, 16'h0007);
		chk("top off", {12'h000, sysTpoe, sysTi}, 16'h0000);
		@(posedge ref_clk);
		sysDoe <= 1'b0;
		sysOnly <= 1'b1;
		@(posedge ref_clk);
		#1 chk("sys float", sysDi, 16'hffff);
		chk("top on", {9'h000, sysTpoe, sysTpo, sysTi}, 16'h006e);
		$display("test disabled port done");
		conclude();
	end
endmodule

/* File: verilog/hpp_device.sv */
/*
 * Device end of the parallel host port, plus the FIFO that carries host writes to the FIFO address inward.
 * Assumes host strobes held long enough to pass a two-stage synchroniser plus one cycle.
 */
`timescale 1ns/1ps
`include "hpp_consts.svh"

module hpp_fifo #(
	parameter int W = 16,
	parameter int DEPTH = `HPP_FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign inReady = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////

module hpp_device #(
	parameter int DW = 16,
	parameter int DEPTH = `HPP_FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	hpp_if.dev hp,
	input wire logic hostPortEnable,
	input wire logic sysOnlyMode,
	input wire logic [15:0] sysDataOut,
	input wire logic sysDataOe,
	output logic [15:0] sysDataIn,
	input wire logic [2:0] sysTopOut,
	input wire logic sysTopOe,
	output logic [2:0] sysTopPinOut,
	output logic sysTopPinOe,
	input wire logic [2:0] sysTopPinIn,
	output logic [2:0] sysTopIn,
	input wire logic [4:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdata,
	output logic [DW-1:0] rxData,
	output logic rxValid,
	input wire logic rxReady
);
	// pin level from request state: {oe, out}
	function automatic logic [1:0] reqPin(input logic active, input logic pol,
		input logic od, input logic en);
		logic lvl;
		lvl = active ~^ pol;
		if (!en) begin
			reqPin = 2'b00;
		end else if (od) begin
			reqPin = {~lvl, 1'b0};
		end else begin
			reqPin = {1'b1, lvl};
		end
	endfunction

	localparam int NS = 6;
	logic [NS-1:0] syncA;
	logic [NS-1:0] syncB;
	logic rdPrev;
	logic wrPrev;
	logic ackPrev;
	logic [3:0] ctrl;
	logic overflow;
	logic rxPend;
	logic rdOe;
	logic [15:0] rdData;
	logic [15:0] hostReg [16];
	logic sel;
	logic rdAct;
	logic wrAct;
	logic rdStart;
	logic wrStart;
	logic ackStart;
	logic ackAct;
	logic doubleReq;
	logic pushValid;
	logic pushReady;
	logic [DW-1:0] pushData;
	logic fifoPush;
	logic [15:0] wrWord;
	logic [1:0] svcPin;
	logic [1:0] txPin;
	logic [1:0] rxPin;

	////////////////////////////////////////////////////////////////////////////
	// synchroniser; first stage feeds only the second
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= '0;
			syncB <= '0;
		end else begin
			syncA <= {hp.ack, hp.singleStrobe, hp.writeStrobe, hp.readStrobe, hp.selB,
				hp.selA};
			syncB <= syncA;
		end
	end

	assign sel = hostPortEnable & (syncB[0] | syncB[1]);
	// polarity applied before edge detection; strobePol high means active high
	always_comb begin
		if (hp.dualStrobe) begin
			rdAct = sel & (syncB[2] ~^ hp.strobePol);
			wrAct = sel & (syncB[3] ~^ hp.strobePol);
		end else begin
			rdAct = sel & (syncB[4] ~^ hp.strobePol) & hp.rw;
			wrAct = sel & (syncB[4] ~^ hp.strobePol) & ~hp.rw;
		end
	end
	assign doubleReq = ctrl[`HPP_CTRL_DOUBLE_REQ];
	// acknowledge only has meaning with a single request line
	assign ackAct = hostPortEnable & ~doubleReq & (syncB[5] ~^ ctrl[`HPP_CTRL_ACK_POL]);
	assign rdStart = rdAct & ~rdPrev;
	assign wrStart = wrAct & ~wrPrev;
	assign ackStart = ackAct & ~ackPrev;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			// start set: a level already active at reset release is no edge
			rdPrev <= 1'b1;
			wrPrev <= 1'b1;
			ackPrev <= 1'b1;
		end else begin
			rdPrev <= rdAct;
			wrPrev <= wrAct;
			ackPrev <= ackAct;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// host access; address and data are held by the host for the whole strobe
	assign wrWord = hp.byteWidth ? {8'h00, hp.dataBus[7:0]} : hp.dataBus;
	assign fifoPush = wrStart & (hp.addr == `HPP_FIFO_ADDR);
	assign pushValid = fifoPush;
	assign pushData = DW'(wrWord);

	always_ff @(posedge ref_clk) begin
		if (wrStart && hp.addr != `HPP_FIFO_ADDR) begin
			if (hp.byteWidth) begin
				hostReg[hp.addr][7:0] <= hp.dataBus[7:0];
			end else begin
				hostReg[hp.addr] <= hp.dataBus;
			end
		end else if (regWrite && regAddr[`HPP_DEV_HREG_BIT]) begin
			hostReg[regAddr[3:0]] <= regWdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData <= 16'h0000;
			rdOe <= 1'b0;
		end else begin
			if (rdStart) begin
				rdData <= hp.byteWidth ? {8'h00, hostReg[hp.addr][7:0]} : hostReg[hp.addr];
			end
			rdOe <= rdAct;
		end
	end

	hpp_fifo #(.W(DW), .DEPTH(DEPTH)) inFifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.inValid(pushValid),
		.inReady(pushReady),
		.inData(pushData),
		.outValid(rxValid),
		.outReady(rxReady),
		.outData(rxData)
	);

	////////////////////////////////////////////////////////////////////////////
	// shared data pins: host bus when enabled, system data bits otherwise
	always_comb begin
		if (hostPortEnable) begin
			hp.dataDev = rdData;
			hp.dataDevOe = rdOe ? (hp.byteWidth ? 16'h00ff : 16'hffff) : 16'h0000;
			sysDataIn = 16'h0000;
		end else begin
			hp.dataDev = sysDataOut;
			hp.dataDevOe = {16{sysDataOe}};
			sysDataIn = hp.dataBus;
		end
	end

	// top bits serve the system bus only in system-only mode
	assign sysTopPinOut = sysTopOut;
	assign sysTopPinOe = sysOnlyMode & sysTopOe;
	assign sysTopIn = sysOnlyMode ? sysTopPinIn : 3'h0;
	// no other dedicated pin of the group has any host function here

	////////////////////////////////////////////////////////////////////////////
	// requests: transmit = room for host writes, receive = data waiting for host
	assign svcPin = reqPin(rxPend, ctrl[`HPP_CTRL_REQ_POL], ctrl[`HPP_CTRL_REQ_OD],
		hostPortEnable & ~doubleReq);
	assign txPin = reqPin(pushReady, ctrl[`HPP_CTRL_REQ_POL], ctrl[`HPP_CTRL_REQ_OD],
		hostPortEnable & doubleReq);
	assign rxPin = reqPin(rxPend, ctrl[`HPP_CTRL_REQ_POL], ctrl[`HPP_CTRL_REQ_OD],
		hostPortEnable & doubleReq);
	assign hp.svcReqOe = svcPin[1];
	assign hp.svcReqOut = svcPin[0];
	assign hp.txReqOe = txPin[1];
	assign hp.txReqOut = txPin[0];
	assign hp.rxReqOe = rxPin[1];
	assign hp.rxReqOut = rxPin[0];

	////////////////////////////////////////////////////////////////////////////
	// user register port; set beats clear on every sticky flag
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `HPP_DEV_CTRL_RESET;
		end else if (regWrite && regAddr == `HPP_DEV_CTRL) begin
			ctrl <= regWdata[3:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxPend <= 1'b0;
		end else if (regWrite && regAddr == `HPP_DEV_RXREQ && regWdata[0]) begin
			rxPend <= 1'b1;
		end else if (doubleReq ? rdStart : ackStart) begin
			rxPend <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			overflow <= 1'b0;
		end else if (fifoPush && !pushReady) begin
			overflow <= 1'b1;
		end else if (regWrite && regAddr == `HPP_DEV_STATUS && regWdata[`HPP_STAT_OVERFLOW]) begin
			overflow <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 16'h0000;
		end else if (regRead) begin
			if (regAddr[`HPP_DEV_HREG_BIT]) begin
				regRdata <= hostReg[regAddr[3:0]];
			end else if (regAddr == `HPP_DEV_CTRL) begin
				regRdata <= {12'h000, ctrl};
			end else if (regAddr == `HPP_DEV_STATUS) begin
				regRdata <= {12'h000, hostPortEnable, ~pushReady, rxPend, overflow};
			end else begin
				regRdata <= 16'h0000;
			end
		end else begin
			regRdata <= 16'h0000;
		end
	end
endmodule

/* File: verilog/hpp_host.sv */
/*
 * Host end of the parallel host port: runs one pin-level access per command.
 * Assumes the device end and pull-ups through hpp_if; one access at a time.
 */
`timescale 1ns/1ps
`include "hpp_consts.svh"

module hpp_host #(
	parameter int STROBE_CYC = `HPP_STROBE_CYC,
	parameter int SETUP_CYC = `HPP_SETUP_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	hpp_if.host hp,
	input wire logic [2:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdata
);
	hpp_pkg::hpp_state_e state;
	logic [7:0] cnt;
	logic [7:0] ackCnt;
	logic isRead;
	logic [3:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [4:0] cfg;
	logic strobeOn;
	logic go;

	assign go = regWrite && regAddr == `HPP_HST_CMD && regWdata[`HPP_CMD_GO];

	// busy hosts ignore a new go
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= hpp_pkg::HPP_IDLE;
			cnt <= 8'h00;
			isRead <= 1'b0;
		end else begin
			case (state)
				hpp_pkg::HPP_IDLE: begin
					if (go) begin
						isRead <= regWdata[`HPP_CMD_READ];
						state <= hpp_pkg::HPP_SETUP;
						cnt <= 8'(SETUP_CYC - 1);
					end
				end
				hpp_pkg::HPP_SETUP: begin
					if (cnt == 8'h00) begin
						state <= hpp_pkg::HPP_STROBE;
						cnt <= 8'(STROBE_CYC - 1);
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				hpp_pkg::HPP_STROBE: begin
					if (cnt == 8'h00) begin
						state <= hpp_pkg::HPP_HOLD;
						cnt <= 8'(SETUP_CYC - 1);
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				hpp_pkg::HPP_HOLD: begin
					if (cnt == 8'h00) begin
						state <= hpp_pkg::HPP_IDLE;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				default: begin
					state <= hpp_pkg::HPP_IDLE;
				end
			endcase
		end
	end

	// read data captured at the last strobe cycle, well after the device drives
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
		end else if (state == hpp_pkg::HPP_STROBE && cnt == 8'h00 && isRead) begin
			rdata <= cfg[`HPP_CFG_BYTE] ? {8'h00, hp.dataBus[7:0]} : hp.dataBus;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr <= 4'h0;
			wdata <= 16'h0000;
			cfg <= `HPP_HST_CFG_RESET;
		end else if (regWrite && state == hpp_pkg::HPP_IDLE) begin
			if (regAddr == `HPP_HST_ADDR) begin
				addr <= regWdata[3:0];
			end
			if (regAddr == `HPP_HST_WDATA) begin
				wdata <= regWdata;
			end
			if (regAddr == `HPP_HST_CFG) begin
				cfg <= regWdata[4:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ackCnt <= 8'h00;
		end else if (regWrite && regAddr == `HPP_HST_CMD && regWdata[`HPP_CMD_ACK]) begin
			ackCnt <= 8'(STROBE_CYC);
		end else if (ackCnt != 8'h00) begin
			ackCnt <= ackCnt - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pins
	assign strobeOn = (state == hpp_pkg::HPP_STROBE);
	assign hp.addr = addr;
	// writes use one select and reads the other, so both inputs see traffic
	assign hp.selA = (state != hpp_pkg::HPP_IDLE) & ~isRead;
	assign hp.selB = (state != hpp_pkg::HPP_IDLE) & isRead;
	assign hp.rw = isRead;
	assign hp.singleStrobe = (strobeOn & ~cfg[`HPP_CFG_DUAL]) ~^ cfg[`HPP_CFG_STROBE_POL];
	assign hp.readStrobe = (strobeOn & cfg[`HPP_CFG_DUAL] & isRead)
		~^ cfg[`HPP_CFG_STROBE_POL];
	assign hp.writeStrobe = (strobeOn & cfg[`HPP_CFG_DUAL] & ~isRead)
		~^ cfg[`HPP_CFG_STROBE_POL];
	assign hp.ack = (ackCnt != 8'h00) ~^ cfg[`HPP_CFG_ACK_POL];
	assign hp.strobePol = cfg[`HPP_CFG_STROBE_POL];
	assign hp.dualStrobe = cfg[`HPP_CFG_DUAL];
	assign hp.byteWidth = cfg[`HPP_CFG_BYTE];
	assign hp.dataHost = wdata;
	assign hp.dataHostOe = (state != hpp_pkg::HPP_IDLE && !isRead)
		? (cfg[`HPP_CFG_BYTE] ? 16'h00ff : 16'hffff) : 16'h0000;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 16'h0000;
		end else if (regRead) begin
			case (regAddr)
				`HPP_HST_ADDR: regRdata <= {12'h000, addr};
				`HPP_HST_WDATA: regRdata <= wdata;
				`HPP_HST_CFG: regRdata <= {11'h000, cfg};
				`HPP_HST_STATUS: regRdata <= {12'h000,
					hp.rxReq ~^ cfg[`HPP_CFG_REQ_POL], hp.txReq ~^ cfg[`HPP_CFG_REQ_POL],
					hp.svcReq ~^ cfg[`HPP_CFG_REQ_POL], state != hpp_pkg::HPP_IDLE};
				`HPP_HST_RDATA: regRdata <= rdata;
				default: regRdata <= 16'h0000;
			endcase
		end else begin
			regRdata <= 16'h0000;
		end
	end
endmodule
